// >>> logic/dsc_pkg.sv
// Constants shared by the dual serial card glue logic.
package dsc_pkg;
  // Register byte offsets on the AHB-Lite bus.
  localparam logic [7:0] DSC_CTRL_OFS = 8'h00;
  localparam logic [7:0] DSC_ADDR_CFG_OFS = 8'h04;
  localparam logic [7:0] DSC_IRQ_CFG_OFS = 8'h08;
  localparam logic [7:0] DSC_CLK_CFG_OFS = 8'h0c;
  localparam logic [7:0] DSC_BASES_OFS = 8'h10;
  localparam logic [7:0] DSC_INFO_OFS = 8'h14;
  localparam logic [7:0] DSC_INT_STATUS_OFS = 8'h18;
  localparam logic [7:0] DSC_INT_ENABLE_OFS = 8'h1c;
  localparam logic [7:0] DSC_INT_CLEAR_OFS = 8'h20;
  // Field positions.
  localparam int DSC_CTRL_USE_STRAPS = 0;
  localparam int DSC_ADDR_P2EN = 4;
  localparam int DSC_IRQ_P2_LINE = 4;
  localparam int DSC_IRQ_P1_MODE = 8;
  localparam int DSC_IRQ_P2_MODE = 10;
  localparam int DSC_CLK_P2 = 2;
  localparam int DSC_INFO_DEPTH = 8;
  // Reset values: first port at 3F8 on line 4, second at 2F8 on line 3.
  localparam logic [3:0] DSC_ADDR_CODE_RST = 4'h1;
  localparam logic DSC_P2EN_RST = 1'h1;
  localparam logic [3:0] DSC_P1_LINE_RST = 4'h4;
  localparam logic [3:0] DSC_P2_LINE_RST = 4'h3;
  localparam logic [1:0] DSC_MODE_RST = 2'h0;
  localparam logic [1:0] DSC_PRESC_RST = 2'h0;
  // Switch code value that turns both decoders off.
  localparam logic [3:0] DSC_ADDR_CODE_OFF = 4'hf;
  // Interrupt line modes.
  localparam logic [1:0] DSC_MODE_NORMAL = 2'h0;
  localparam logic [1:0] DSC_MODE_SHARED = 2'h1;
  localparam logic [1:0] DSC_MODE_PULLDN = 2'h2;
  // Prescaler selections.
  localparam logic [1:0] DSC_PRESC_DIV4 = 2'h0;
  localparam logic [1:0] DSC_PRESC_DIV2 = 2'h1;
  localparam logic [1:0] DSC_PRESC_DIV1 = 2'h2;
  // Host interrupt lines that may be chosen.
  localparam logic [15:0] DSC_IRQ_LEGAL = 16'h9cbc;
  // Controller FIFO depth in bytes for each card variant.
  localparam logic [7:0] DSC_FIFO_DEPTH_SMALL = 8'h20;
  localparam logic [7:0] DSC_FIFO_DEPTH_LARGE = 8'h80;
  // Serial port window: eight locations, so three index bits.
  localparam int DSC_WIN_BITS = 3;
  localparam int DSC_NUM_EVENTS = 2;
endpackage : dsc_pkg

// >>> logic/dsc_glue.sv
// Glue logic for a two-port serial adapter: decode, interrupt routing, prescalers.
// Behaviour
// - each enabled port answers eight consecutive host I/O addresses from its base.
// - four-position switch code selects both ports' base pair, e.g. 3F8 and 2F8.
// - extended pairs such as 3220/3228 exist; all-Off code disables both ports.
// - second port enabled with its enable strap fitted, disabled when removed.
// - with second port disabled, only the first port's address is decoded.
// - each port interrupt routes to lines 2-5,7,10,11,12,15 or to none.
// - reset defaults put port one at 3F8/line 4, port two at 2F8/line 3.
// - normal mode drives the port's own interrupt line exclusively, both levels.
// - shared mode lets several ports drive one line; a pull-down is needed.
// - each port has its own prescaler dividing the reference by 4, 2 or 1.
// - divide by 4 gives the conventional rates up to 115,200 bps.
// - divide by 2 doubles every rate, up to 230.4 Kbps.
// - divide by 1 quadruples every rate, up to 460.8 Kbps.
// - controller FIFOs are 32 bytes on one variant and 128 on the other.
//
// The AHB-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module dsc_glue
  import dsc_pkg::*;
#(
  parameter bit LARGE_FIFO = 1'b0
)
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Board straps and address switch.
  input wire logic [3:0] address_select_switch,
  input wire logic port2_enable_strap,
  input wire logic [3:0] port1_irq_route_strap,
  input wire logic [3:0] port2_irq_route_strap,
  input wire logic [3:0] irq_mode_strap,
  input wire logic [1:0] port1_prescale_strap,
  input wire logic [1:0] port2_prescale_strap,
  // Host I/O cycle.
  input wire logic [15:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  // Serial controller side.
  output logic port1_cs,
  output logic port2_cs,
  output logic [2:0] port_reg_index,
  output logic port1_clk_tick,
  output logic port2_clk_tick,
  input wire logic port1_ctl_irq,
  input wire logic port2_ctl_irq,
  // Host interrupt request lines, tri-state style with pull-downs.
  output logic [15:0] host_irq_out,
  output logic [15:0] host_irq_oe,
  output logic [15:0] host_irq_pulldown,
  // Block interrupt.
  output logic irq
);

  typedef struct packed {
    logic use_straps;
    logic [3:0] addr_code;
    logic p2_en;
    logic [3:0] p1_line;
    logic [3:0] p2_line;
    logic [1:0] p1_mode;
    logic [1:0] p2_mode;
    logic [1:0] p1_presc;
    logic [1:0] p2_presc;
    logic [1:0] p1_cnt;
    logic [1:0] p2_cnt;
    logic p1_tick;
    logic p2_tick;
    logic p1_cs;
    logic p2_cs;
    logic [2:0] reg_index;
    logic [15:0] irq_out;
    logic [15:0] irq_oe;
    logic [15:0] irq_pd;
    logic [1:0] ctl_irq_prev;
    logic [1:0] int_status;
    logic [1:0] int_enable;
    logic irq;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic readyout;
  } dsc_state_s;

  dsc_state_s state_ff;
  dsc_state_s nxt_state;

  // Base pair for a switch code: {valid, first base, second base}.
  function automatic logic [32:0] dsc_base_pair(input logic [3:0] code);
    logic [32:0] pair;
    pair = 33'h0;
    unique case (code)
      4'h1: pair = {1'b1, 16'h03f8, 16'h02f8};
      4'h2: pair = {1'b1, 16'h03e8, 16'h02e8};
      4'h3: pair = {1'b1, 16'h02f8, 16'h02e8};
      4'h4: pair = {1'b1, 16'h02f8, 16'h03e8};
      4'h5: pair = {1'b1, 16'h3220, 16'h3228};
      4'h6: pair = {1'b1, 16'h4220, 16'h4228};
      4'h7: pair = {1'b1, 16'h5220, 16'h5228};
      4'h8: pair = {1'b1, 16'h5220, 16'h4220};
      4'h9: pair = {1'b1, 16'h0280, 16'h0290};
      4'ha: pair = {1'b1, 16'h0300, 16'h0308};
      4'hb: pair = {1'b1, 16'h0310, 16'h0318};
      4'hc: pair = {1'b1, 16'h0280, 16'h0288};
      4'hd: pair = {1'b1, 16'h0290, 16'h0298};
      4'he: pair = {1'b1, 16'h0300, 16'h0280};
      default: pair = 33'h0;
    endcase
    return pair;
  endfunction : dsc_base_pair

  // One-hot host line for a route code; illegal codes select no line.
  function automatic logic [15:0] dsc_line_hot(input logic [3:0] line);
    logic [15:0] hot;
    hot = 16'h0001 << line;
    return hot & DSC_IRQ_LEGAL;
  endfunction : dsc_line_hot

  // Last count of the prescaler counter for a selection.
  function automatic logic [1:0] dsc_div_last(input logic [1:0] presc);
    logic [1:0] last;
    unique case (presc)
      DSC_PRESC_DIV2: last = 2'h1;
      DSC_PRESC_DIV1: last = 2'h0;
      default: last = 2'h3;
    endcase
    return last;
  endfunction : dsc_div_last

  // Port drive onto its selected line for a given mode.
  function automatic logic [47:0] dsc_drive(input logic [15:0] hot, input logic [1:0] mode,
                                            input logic req);
    logic [15:0] o;
    logic [15:0] oe;
    logic [15:0] pd;
    o = 16'h0;
    oe = 16'h0;
    pd = 16'h0;
    if (mode == DSC_MODE_SHARED || mode == DSC_MODE_PULLDN)
    begin
      o = hot;
      oe = req ? hot : 16'h0;
      pd = (mode == DSC_MODE_PULLDN) ? hot : 16'h0;
    end
    else
    begin
      o = req ? hot : 16'h0;
      oe = hot;
    end
    return {o, oe, pd};
  endfunction : dsc_drive

  logic [3:0] eff_code;
  logic eff_p2_en;
  logic [3:0] eff_p1_line;
  logic [3:0] eff_p2_line;
  logic [1:0] eff_p1_mode;
  logic [1:0] eff_p2_mode;
  logic [1:0] eff_p1_presc;
  logic [1:0] eff_p2_presc;
  logic [32:0] pair;
  logic io_cycle;
  logic addr_phase;
  logic [47:0] drv1;
  logic [47:0] drv2;
  logic [1:0] events;
  logic [7:0] rd_ofs;

  always_comb
  begin
    nxt_state = state_ff;
    // Live straps take over from the registers when software asks for it.
    eff_code = state_ff.use_straps ? address_select_switch : state_ff.addr_code;
    eff_p2_en = state_ff.use_straps ? port2_enable_strap : state_ff.p2_en;
    eff_p1_line = state_ff.use_straps ? port1_irq_route_strap : state_ff.p1_line;
    eff_p2_line = state_ff.use_straps ? port2_irq_route_strap : state_ff.p2_line;
    eff_p1_mode = state_ff.use_straps ? irq_mode_strap[1:0] : state_ff.p1_mode;
    eff_p2_mode = state_ff.use_straps ? irq_mode_strap[3:2] : state_ff.p2_mode;
    eff_p1_presc = state_ff.use_straps ? port1_prescale_strap : state_ff.p1_presc;
    eff_p2_presc = state_ff.use_straps ? port2_prescale_strap : state_ff.p2_presc;

    pair = dsc_base_pair(eff_code);
    io_cycle = io_rd | io_wr;
    nxt_state.p1_cs = io_cycle && pair[32] &&
      (io_addr[15:DSC_WIN_BITS] == pair[31:16+DSC_WIN_BITS]);
    nxt_state.p2_cs = io_cycle && pair[32] && eff_p2_en &&
      (io_addr[15:DSC_WIN_BITS] == pair[15:DSC_WIN_BITS]);
    nxt_state.reg_index = io_addr[DSC_WIN_BITS-1:0];

    if (state_ff.p1_cnt >= dsc_div_last(eff_p1_presc))
    begin
      nxt_state.p1_cnt = 2'h0;
    end
    else
    begin
      nxt_state.p1_cnt = state_ff.p1_cnt + 2'h1;
    end
    if (state_ff.p2_cnt >= dsc_div_last(eff_p2_presc))
    begin
      nxt_state.p2_cnt = 2'h0;
    end
    else
    begin
      nxt_state.p2_cnt = state_ff.p2_cnt + 2'h1;
    end
    nxt_state.p1_tick = (state_ff.p1_cnt >= dsc_div_last(eff_p1_presc));
    nxt_state.p2_tick = (state_ff.p2_cnt >= dsc_div_last(eff_p2_presc));

    drv1 = dsc_drive(dsc_line_hot(eff_p1_line), eff_p1_mode, port1_ctl_irq);
    drv2 = dsc_drive(dsc_line_hot(eff_p2_line), eff_p2_mode, port2_ctl_irq);
    nxt_state.irq_out = drv1[47:32] | drv2[47:32];
    nxt_state.irq_oe = drv1[31:16] | drv2[31:16];
    nxt_state.irq_pd = drv1[15:0] | drv2[15:0];

    // Service requests from the controllers are the block's events.
    events = {port2_ctl_irq & ~state_ff.ctl_irq_prev[1],
              port1_ctl_irq & ~state_ff.ctl_irq_prev[0]};
    nxt_state.ctl_irq_prev = {port2_ctl_irq, port1_ctl_irq};

    // AHB-Lite: zero wait states, always OKAY; reads are prepared in the address phase.
    addr_phase = hsel && htrans[1] && hready;
    rd_ofs = haddr[7:0];
    nxt_state.readyout = 1'b1;
    nxt_state.wr_pend = addr_phase && hwrite;
    nxt_state.wr_addr = haddr[7:0];
    if (addr_phase && !hwrite)
    begin
      unique case (rd_ofs)
        DSC_CTRL_OFS: nxt_state.rdata = {31'h0, state_ff.use_straps};
        DSC_ADDR_CFG_OFS: nxt_state.rdata = {27'h0, state_ff.p2_en, state_ff.addr_code};
        DSC_IRQ_CFG_OFS: nxt_state.rdata = {20'h0, state_ff.p2_mode, state_ff.p1_mode,
                                            state_ff.p2_line, state_ff.p1_line};
        DSC_CLK_CFG_OFS: nxt_state.rdata = {28'h0, state_ff.p2_presc, state_ff.p1_presc};
        DSC_BASES_OFS: nxt_state.rdata = pair[31:0];
        DSC_INFO_OFS: nxt_state.rdata = {16'h0,
          (LARGE_FIFO ? DSC_FIFO_DEPTH_LARGE : DSC_FIFO_DEPTH_SMALL),
          5'h0, eff_p2_en, port2_ctl_irq, port1_ctl_irq};
        DSC_INT_STATUS_OFS: nxt_state.rdata = {30'h0, state_ff.int_status};
        DSC_INT_ENABLE_OFS: nxt_state.rdata = {30'h0, state_ff.int_enable};
        default: nxt_state.rdata = 32'h0;
      endcase
    end
    else
    begin
      nxt_state.rdata = 32'h0;
    end

    if (state_ff.wr_pend)
    begin
      unique case (state_ff.wr_addr)
        DSC_CTRL_OFS: nxt_state.use_straps = hwdata[DSC_CTRL_USE_STRAPS];
        DSC_ADDR_CFG_OFS:
        begin
          nxt_state.addr_code = hwdata[3:0];
          nxt_state.p2_en = hwdata[DSC_ADDR_P2EN];
        end
        DSC_IRQ_CFG_OFS:
        begin
          nxt_state.p1_line = hwdata[3:0];
          nxt_state.p2_line = hwdata[DSC_IRQ_P2_LINE +: 4];
          nxt_state.p1_mode = hwdata[DSC_IRQ_P1_MODE +: 2];
          nxt_state.p2_mode = hwdata[DSC_IRQ_P2_MODE +: 2];
        end
        DSC_CLK_CFG_OFS:
        begin
          nxt_state.p1_presc = hwdata[1:0];
          nxt_state.p2_presc = hwdata[DSC_CLK_P2 +: 2];
        end
        DSC_INT_ENABLE_OFS: nxt_state.int_enable = hwdata[DSC_NUM_EVENTS-1:0];
        DSC_INT_CLEAR_OFS:
          nxt_state.int_status = state_ff.int_status & ~hwdata[DSC_NUM_EVENTS-1:0];
        default: nxt_state.int_status = state_ff.int_status;
      endcase
    end
    // A new event wins over a clear in the same cycle.
    nxt_state.int_status = nxt_state.int_status | events;
    nxt_state.irq = |(state_ff.int_status & state_ff.int_enable);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_ff <= '0;
      state_ff.addr_code <= DSC_ADDR_CODE_RST;
      state_ff.p2_en <= DSC_P2EN_RST;
      state_ff.p1_line <= DSC_P1_LINE_RST;
      state_ff.p2_line <= DSC_P2_LINE_RST;
      state_ff.p1_mode <= DSC_MODE_RST;
      state_ff.p2_mode <= DSC_MODE_RST;
      state_ff.p1_presc <= DSC_PRESC_RST;
      state_ff.p2_presc <= DSC_PRESC_RST;
      state_ff.readyout <= 1'b1;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign hreadyout = state_ff.readyout;
  assign hresp = 1'b0;
  assign hrdata = state_ff.rdata;
  assign port1_cs = state_ff.p1_cs;
  assign port2_cs = state_ff.p2_cs;
  assign port_reg_index = state_ff.reg_index;
  assign port1_clk_tick = state_ff.p1_tick;
  assign port2_clk_tick = state_ff.p2_tick;
  assign host_irq_out = state_ff.irq_out;
  assign host_irq_oe = state_ff.irq_oe;
  assign host_irq_pulldown = state_ff.irq_pd;
  assign irq = state_ff.irq;

endmodule : dsc_glue

// >>> sim/dsc_glue_chk.sv
// Port checker for the dual serial card glue.
`timescale 1ns/1ps
module dsc_glue_chk (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Host I/O cycle and selects.
  input wire logic [15:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic port1_cs,
  input wire logic port2_cs,
  input wire logic [2:0] port_reg_index,
  // Controller clocks and requests.
  input wire logic port1_clk_tick,
  input wire logic port2_clk_tick,
  input wire logic port1_ctl_irq,
  input wire logic port2_ctl_irq,
  // Host interrupt lines.
  input wire logic [15:0] host_irq_out,
  input wire logic [15:0] host_irq_oe
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  chk_cs1_cause: assert property (port1_cs |-> $past(io_rd || io_wr))
    else $error("port1 select without io cycle");
  chk_cs2_cause: assert property (port2_cs |-> $past(io_rd || io_wr))
    else $error("port2 select without io cycle");
  chk_index_follows: assert property ((port1_cs || port2_cs) |->
    port_reg_index == $past(io_addr[2:0]))
    else $error("register index not the low address bits");
  chk_cs_exclusive: assert property (!(port1_cs && port2_cs))
    else $error("both ports selected at once");
  chk_cs_release: assert property (!(io_rd || io_wr) |=> !port1_cs && !port2_cs)
    else $error("select held after io cycle ended");
  // The prescaler needs a few edges after reset before its first tick.
  chk_tick1_gap: assert property (not ((!port1_clk_tick && $past(rst_n)) [*5]))
    else $error("port1 reference tick gap above four");
  chk_tick2_gap: assert property (not ((!port2_clk_tick && $past(rst_n)) [*5]))
    else $error("port2 reference tick gap above four");
  chk_irq_quiet: assert property ((!port1_ctl_irq && !port2_ctl_irq) [*2] |->
    (host_irq_oe & host_irq_out) == 16'h0)
    else $error("line driven high without request");
endmodule : dsc_glue_chk
bind dsc_glue dsc_glue_chk i_dsc_glue_chk (.sys_clk, .rst_n, .io_addr, .io_rd,
  .io_wr, .port1_cs, .port2_cs, .port_reg_index, .port1_clk_tick, .port2_clk_tick,
  .port1_ctl_irq, .port2_ctl_irq, .host_irq_out, .host_irq_oe);

// >>> sim/dsc_host_model.sv
// Host side model: I/O cycles and resolved interrupt line levels.
`timescale 1ns/1ps
module dsc_host_model (
  // Clock.
  input wire logic sys_clk,
  // Host I/O cycle.
  output logic [15:0] io_addr,
  output logic io_rd,
  output logic io_wr,
  // Interrupt lines.
  input wire logic [15:0] host_irq_out,
  input wire logic [15:0] host_irq_oe,
  input wire logic [15:0] host_irq_pulldown,
  output logic [15:0] irq_level
);
  logic [15:0] last_ff = 16'h0;
  initial
  begin
    io_addr = 16'h0;
    io_rd = 1'b0;
    io_wr = 1'b0;
  end
  // line level resolution
  // A floating line drifts to the inverse of its last level.
  assign irq_level = (host_irq_oe & host_irq_out) |
    (~host_irq_oe & ~host_irq_pulldown & ~last_ff);
  always @(posedge sys_clk) last_ff <= irq_level;
  // One I/O cycle; the address bus is released to a changed value after it.
  task automatic io_cycle(input logic [15:0] a, input logic w);
    io_addr <= a;
    io_rd <= !w;
    io_wr <= w;
    @(posedge sys_clk);
    io_rd <= 1'b0;
    io_wr <= 1'b0;
    io_addr <= ~a;
  endtask : io_cycle
endmodule : dsc_host_model

// >>> sim/dsc_glue_tb.sv
// Self-checking bench for the dual serial card glue.
`timescale 1ns/1ps
module dsc_glue_tb
  import dsc_pkg::*;
;
  localparam logic [31:0] P2EN = 32'h1 << DSC_ADDR_P2EN;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [31:0] rd_q;
  logic [3:0] address_select_switch = 4'h1;
  logic port2_enable_strap = 1'b0;
  logic [1:0] port1_prescale_strap = 2'h0;
  logic [15:0] io_addr;
  logic io_rd;
  logic io_wr;
  logic port1_cs;
  logic port2_cs;
  logic [2:0] port_reg_index;
  logic port1_clk_tick;
  logic port2_clk_tick;
  logic port1_ctl_irq = 1'b0;
  logic port2_ctl_irq = 1'b0;
  logic [15:0] host_irq_out;
  logic [15:0] host_irq_oe;
  logic [15:0] host_irq_pulldown;
  logic [15:0] irq_level;
  logic irq;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [31:0] bt [1:14] = '{32'h03f802f8, 32'h03e802e8, 32'h02f802e8, 32'h02f803e8,
    32'h32203228, 32'h42204228, 32'h52205228, 32'h52204220, 32'h02800290,
    32'h03000308, 32'h03100318, 32'h02800288, 32'h02900298, 32'h03000280};
  int ln [9] = '{2, 3, 4, 5, 7, 10, 11, 12, 15};
  dsc_glue i_dsc_glue (.sys_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .address_select_switch,
    .port2_enable_strap, .port1_irq_route_strap(4'h4), .port2_irq_route_strap(4'h3),
    .irq_mode_strap(4'h0), .port1_prescale_strap, .port2_prescale_strap(2'h0),
    .io_addr, .io_rd, .io_wr, .port1_cs, .port2_cs, .port_reg_index, .port1_clk_tick,
    .port2_clk_tick, .port1_ctl_irq, .port2_ctl_irq, .host_irq_out, .host_irq_oe,
    .host_irq_pulldown, .irq);
  dsc_host_model i_dsc_host_model (.sys_clk, .io_addr, .io_rd, .io_wr, .host_irq_out,
    .host_irq_oe, .host_irq_pulldown, .irq_level);
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic report_and_stop;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Values seen just before the edge are the values sampled at it.
  task automatic wait_rdy;
    int n;
    n = 0;
    @(negedge sys_clk);
    while (hreadyout !== 1'b1 && n < 50)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 50)
    begin
      n_mismatch++;
      report_and_stop();
    end
    rd_q = hrdata;
    @(posedge sys_clk);
  endtask : wait_rdy
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask : ahb
  task automatic probe(input logic [15:0] a, input logic w, input logic [1:0] e);
    i_dsc_host_model.io_cycle(a, w);
    #1;
    chk("port select", e, {port1_cs, port2_cs});
    if (e != 2'b00)
      chk("reg index", a[2:0], port_reg_index);
    @(posedge sys_clk);
  endtask : probe
  task automatic ticks(input logic [31:0] e1, input logic [31:0] e2);
    logic [31:0] a;
    logic [31:0] b;
    a = 0;
    b = 0;
    repeat (16)
    begin
      @(posedge sys_clk);
      #1;
      a += port1_clk_tick;
      b += port2_clk_tick;
    end
    chk("port1 ticks", e1, a);
    chk("port2 ticks", e2, b);
    @(posedge sys_clk);
  endtask : ticks
  task automatic t_reset;
    probe(16'h03ff, 1'b0, 2'b10);
    probe(16'h02f8, 1'b1, 2'b01);
    port1_ctl_irq <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk("port1 line", 16'h0010, host_irq_oe & host_irq_out);
    @(posedge sys_clk);
    port1_ctl_irq <= 1'b0;
    port2_ctl_irq <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk("port2 line", 16'h0008, host_irq_oe & host_irq_out);
    @(posedge sys_clk);
    port2_ctl_irq <= 1'b0;
    @(posedge sys_clk);
  endtask : t_reset
  task automatic t_codes;
    logic [15:0] p;
    logic [15:0] q;
    for (int c = 1; c < 15; c++)
    begin
      p = bt[c][31:16];
      q = bt[c][15:0];
      ahb(1'b1, DSC_ADDR_CFG_OFS, 32'(c) | P2EN);
      probe(p + 16'h7, 1'b0, 2'b10);
      probe(q, 1'b1, 2'b01);
      probe(p + 16'h8, 1'b0, {1'b0, p + 16'h8 == q});
    end
    ahb(1'b1, DSC_ADDR_CFG_OFS, 32'hf | P2EN);
    probe(16'h03f8, 1'b0, 2'b00);
    probe(16'h02f8, 1'b0, 2'b00);
  endtask : t_codes
  task automatic t_p2_off;
    ahb(1'b1, DSC_ADDR_CFG_OFS, 32'h1);
    probe(16'h02f8, 1'b0, 2'b00);
    probe(16'h03f8, 1'b0, 2'b10);
    port1_prescale_strap <= DSC_PRESC_DIV1;
    ahb(1'b1, DSC_CTRL_OFS, 32'h1);
    probe(16'h02f8, 1'b0, 2'b00);
    ticks(16, 4);
    port2_enable_strap <= 1'b1;
    @(posedge sys_clk);
    probe(16'h02f8, 1'b0, 2'b01);
    ahb(1'b1, DSC_CTRL_OFS, 32'h0);
    ahb(1'b1, DSC_ADDR_CFG_OFS, 32'h1 | P2EN);
  endtask : t_p2_off
  task automatic t_route;
    for (int i = 0; i < 10; i++)
    begin
      ahb(1'b1, DSC_IRQ_CFG_OFS, 32'h30 | (i < 9 ? ln[i] : 6));
      port1_ctl_irq <= 1'b1;
      @(posedge sys_clk);
      #1;
      chk("routed oe", (i < 9 ? 1 << ln[i] : 0) | 8, host_irq_oe);
      chk("routed out", i < 9 ? 1 << ln[i] : 0, host_irq_out);
      @(posedge sys_clk);
      port1_ctl_irq <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk("driven low", 16'h0, host_irq_out);
      @(posedge sys_clk);
    end
  endtask : t_route
  task automatic t_shared;
    ahb(1'b1, DSC_IRQ_CFG_OFS, 32'h55 | (DSC_MODE_PULLDN << 8) | (DSC_MODE_SHARED << 10));
    @(posedge sys_clk);
    #1;
    chk("pulldown", 16'h0020, host_irq_pulldown);
    chk("idle level", 1'b0, irq_level[5]);
    @(posedge sys_clk);
    port2_ctl_irq <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk("shared oe", 16'h0020, host_irq_oe);
    chk("shared level", 1'b1, irq_level[5]);
    @(posedge sys_clk);
    port2_ctl_irq <= 1'b0;
    ahb(1'b1, DSC_IRQ_CFG_OFS, 32'h55 | (DSC_MODE_SHARED << 8) | (DSC_MODE_SHARED << 10));
    @(posedge sys_clk);
    #1;
    chk("no pulldown", 16'h0, host_irq_pulldown);
    @(posedge sys_clk);
    ahb(1'b1, DSC_IRQ_CFG_OFS, 32'h34);
  endtask : t_shared
  task automatic t_presc;
    for (int s = 0; s < 3; s++)
    begin
      ahb(1'b1, DSC_CLK_CFG_OFS, 32'(s) | (32'(2 - s) << DSC_CLK_P2));
      ticks(4 << s, 4 << (2 - s));
    end
  endtask : t_presc
  task automatic t_int;
    ahb(1'b0, DSC_INFO_OFS, 32'h0);
    chk("fifo depth", DSC_FIFO_DEPTH_SMALL, rd_q[15:8]);
    chk("response", 32'h0, hresp);
    ahb(1'b0, 8'h24, 32'h0);
    chk("unmapped", 32'h0, rd_q);
    // Earlier scenarios left events behind; start from a clean status.
    ahb(1'b1, DSC_INT_CLEAR_OFS, 32'h3);
    ahb(1'b0, DSC_INT_STATUS_OFS, 32'h0);
    chk("status clear", 32'h0, rd_q);
    ahb(1'b1, DSC_INT_ENABLE_OFS, 32'h1);
    port1_ctl_irq <= 1'b1;
    repeat (3) @(posedge sys_clk);
    port1_ctl_irq <= 1'b0;
    port2_ctl_irq <= 1'b1;
    #1;
    chk("irq on", 1'b1, irq);
    repeat (3) @(posedge sys_clk);
    port2_ctl_irq <= 1'b0;
    ahb(1'b0, DSC_INT_STATUS_OFS, 32'h0);
    chk("status", 32'h3, rd_q);
    ahb(1'b1, DSC_INT_CLEAR_OFS, 32'h1);
    @(posedge sys_clk);
    #1;
    chk("irq masked", 1'b0, irq);
    @(posedge sys_clk);
    ahb(1'b1, DSC_INT_ENABLE_OFS, 32'h2);
    @(posedge sys_clk);
    #1;
    chk("irq enabled", 1'b1, irq);
    @(posedge sys_clk);
    ahb(1'b1, DSC_INT_CLEAR_OFS, 32'h2);
    @(posedge sys_clk);
    #1;
    chk("irq cleared", 1'b0, irq);
    @(posedge sys_clk);
  endtask : t_int
  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_codes();
    t_p2_off();
    t_route();
    t_shared();
    t_presc();
    t_int();
    report_and_stop();
  end
endmodule : dsc_glue_tb
